// ---- rtl/sfl_assembler.sv ----
`timescale 1ns/10ps
`include "sfl_params.svh"
module sfl_assembler
  import sfl_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  // Received byte stream
  input  wire logic       rx_valid_i,
  input  wire logic [7:0] rx_byte_i,
  // Packet towards the interpreter
  sfl_pkt_if.asm_mp       pkt
);
  sfl_asm_state_type state_r, state_nxt;
  logic [7:0] len_r, len_nxt;
  logic [7:0] sum_r, sum_nxt;
  logic [7:0] acc_r, acc_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic       valid_r, valid_nxt;
  logic       good_r, good_nxt;
  logic [7:0] buf_r   [0:8];
  logic [7:0] buf_nxt [0:8];

  always_comb begin
    state_nxt = state_r;
    len_nxt   = len_r;
    sum_nxt   = sum_r;
    acc_nxt   = acc_r;
    cnt_nxt   = cnt_r;
    valid_nxt = 1'b0;
    good_nxt  = good_r;
    buf_nxt   = buf_r;
    case (state_r)
      SFL_HUNT: begin
        // Zero padding is dropped; bytes during a busy command are lost
        if (rx_valid_i && rx_byte_i != 8'h00 && !pkt.busy) begin
          len_nxt   = rx_byte_i;
          state_nxt = SFL_SUM;
        end
      end
      SFL_SUM: begin
        if (rx_valid_i) begin
          sum_nxt = rx_byte_i;
          acc_nxt = 8'h00;
          cnt_nxt = 8'h00;
          if (len_r < `SFL_LEN_MIN) begin
            valid_nxt = 1'b1;
            good_nxt  = 1'b0;
            state_nxt = SFL_HUNT;
          end else begin
            state_nxt = SFL_DATA;
          end
        end
      end
      SFL_DATA: begin
        if (rx_valid_i) begin
          if (cnt_r < 8'(`SFL_BUF_BYTES))
            buf_nxt[cnt_r[3:0]] = rx_byte_i;
          acc_nxt = acc_r + rx_byte_i;
          cnt_nxt = cnt_r + 8'h01;
          if (cnt_r + `SFL_LEN_HDR + 8'h01 == len_r) begin
            valid_nxt = 1'b1;
            good_nxt  = (8'(acc_r + rx_byte_i) == sum_r) && (len_r <= `SFL_LEN_MAX);
            state_nxt = SFL_HUNT;
          end
        end
      end
      default: state_nxt = SFL_HUNT;
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_r <= SFL_HUNT;
      len_r   <= 8'h00;
      sum_r   <= 8'h00;
      acc_r   <= 8'h00;
      cnt_r   <= 8'h00;
      valid_r <= 1'b0;
      good_r  <= 1'b0;
      for (int i = 0; i < `SFL_BUF_BYTES; i++) buf_r[i] <= 8'h00;
    end else begin
      state_r <= state_nxt;
      len_r   <= len_nxt;
      sum_r   <= sum_nxt;
      acc_r   <= acc_nxt;
      cnt_r   <= cnt_nxt;
      valid_r <= valid_nxt;
      good_r  <= good_nxt;
      buf_r   <= buf_nxt;
    end
  end

  assign pkt.pkt_valid = valid_r;
  assign pkt.pkt_good  = good_r;
  assign pkt.pkt_len   = len_r;
  assign pkt.pkt_data  = buf_r;

  AST_ZERO_SKIPPED: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (state_r == SFL_HUNT && rx_valid_i && rx_byte_i == 8'h00) |=> state_r == SFL_HUNT)
    else $error("Zero byte taken as a packet length");
endmodule

// ---- rtl/sfl_cmd.sv ----
`timescale 1ns/10ps
`include "sfl_params.svh"
module sfl_cmd
  import sfl_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  // Received bytes from the serial link
  input  wire logic        rx_valid_i,
  input  wire logic [7:0]  rx_byte_i,
  // Answer byte to the serial link
  output logic             tx_valid_o,
  output logic [7:0]       tx_byte_o,
  input  wire logic        tx_ready_i,
  // Flash erase
  output logic             erase_req_o,
  output logic [31:0]      erase_addr_o,
  output logic [31:0]      erase_len_o,
  input  wire logic        erase_done_i,
  input  wire logic        erase_err_i,
  // Flash byte program
  output logic             prog_req_o,
  output logic [31:0]      prog_addr_o,
  output logic [7:0]       prog_data_o,
  input  wire logic        prog_done_i,
  input  wire logic        prog_err_i,
  // Execution control
  output logic             run_o,
  output logic [31:0]      run_addr_o,
  output logic             sw_reset_o
);
  sfl_pkt_if pkt ();

  sfl_assembler u_asm (
    .clk_i      (clk_i),
    .resetn_i   (resetn_i),
    .rx_valid_i (rx_valid_i),
    .rx_byte_i  (rx_byte_i),
    .pkt        (pkt)
  );

  sfl_cmd_state_type state_r, state_nxt;
  sfl_act_type       act_r, act_nxt;
  logic [31:0] wr_addr_r, wr_addr_nxt;
  logic [31:0] remain_r, remain_nxt;
  logic [31:0] rem_work_r, rem_work_nxt;
  logic        chunk_ok_r, chunk_ok_nxt;
  logic [3:0]  idx_r, idx_nxt;
  logic [3:0]  nbytes_r, nbytes_nxt;
  logic        tx_valid_nxt;
  logic [7:0]  tx_byte_nxt;
  logic        erase_req_nxt;
  logic [31:0] erase_addr_nxt, erase_len_nxt;
  logic        prog_req_nxt;
  logic [31:0] prog_addr_nxt;
  logic [7:0]  prog_data_nxt;
  logic        run_nxt;
  logic [31:0] run_addr_nxt;
  logic        sw_reset_nxt;
  logic [7:0]  cmd;
  logic [31:0] word_a, word_b;

  assign pkt.busy = (state_r != SFL_IDLE);
  assign cmd      = pkt.pkt_data[0];
  // Parameters arrive most significant byte first
  assign word_a   = {pkt.pkt_data[1], pkt.pkt_data[2], pkt.pkt_data[3], pkt.pkt_data[4]};
  assign word_b   = {pkt.pkt_data[5], pkt.pkt_data[6], pkt.pkt_data[7], pkt.pkt_data[8]};

  always_comb begin
    state_nxt      = state_r;
    act_nxt        = act_r;
    wr_addr_nxt    = wr_addr_r;
    remain_nxt     = remain_r;
    rem_work_nxt   = rem_work_r;
    chunk_ok_nxt   = chunk_ok_r;
    idx_nxt        = idx_r;
    nbytes_nxt     = nbytes_r;
    tx_byte_nxt    = tx_byte_o;
    erase_req_nxt  = erase_req_o;
    erase_addr_nxt = erase_addr_o;
    erase_len_nxt  = erase_len_o;
    prog_req_nxt   = prog_req_o;
    prog_addr_nxt  = prog_addr_o;
    prog_data_nxt  = prog_data_o;
    run_nxt        = 1'b0;
    run_addr_nxt   = run_addr_o;
    sw_reset_nxt   = 1'b0;
    case (state_r)
      SFL_IDLE: begin
        if (pkt.pkt_valid) begin
          tx_byte_nxt  = `SFL_NAK;
          act_nxt      = SFL_ACT_NONE;
          chunk_ok_nxt = 1'b0;
          state_nxt    = SFL_ANSWER;
          if (pkt.pkt_good) begin
            case (cmd)
              `SFL_CMD_SETUP: begin
                if (pkt.pkt_len == `SFL_LEN_SETUP) begin
                  wr_addr_nxt    = word_a;
                  remain_nxt     = word_b;
                  erase_addr_nxt = word_a;
                  erase_len_nxt  = word_b;
                  erase_req_nxt  = 1'b1;
                  state_nxt      = SFL_ERASE;
                end
              end
              `SFL_CMD_CHUNK: begin
                if (chunk_ok_r && pkt.pkt_len >= `SFL_LEN_CHUNK_MIN && pkt.pkt_len <= `SFL_LEN_MAX) begin
                  nbytes_nxt    = 4'(pkt.pkt_len - `SFL_LEN_MIN);
                  idx_nxt       = 4'h0;
                  prog_addr_nxt = wr_addr_r;
                  rem_work_nxt  = remain_r;
                  chunk_ok_nxt  = 1'b1;
                  state_nxt     = SFL_PROG;
                end
              end
              `SFL_CMD_JUMP: begin
                if (pkt.pkt_len == `SFL_LEN_JUMP) begin
                  tx_byte_nxt  = `SFL_ACK;
                  run_addr_nxt = word_a;
                  act_nxt      = SFL_ACT_RUN;
                end
              end
              `SFL_CMD_RESTART: begin
                if (pkt.pkt_len == `SFL_LEN_RESTART) begin
                  tx_byte_nxt = `SFL_ACK;
                  act_nxt     = SFL_ACT_RST;
                end
              end
              default: tx_byte_nxt = `SFL_NAK;
            endcase
          end
        end
      end
      SFL_ERASE: begin
        if (erase_done_i) begin
          erase_req_nxt = 1'b0;
          tx_byte_nxt   = erase_err_i ? `SFL_NAK : `SFL_ACK;
          chunk_ok_nxt  = !erase_err_i;
          state_nxt     = SFL_ANSWER;
        end
      end
      SFL_PROG: begin
        if (!prog_req_o && (idx_r == nbytes_r || rem_work_r == 32'h0)) begin
          wr_addr_nxt = prog_addr_o;
          remain_nxt  = rem_work_r;
          tx_byte_nxt = `SFL_ACK;
          state_nxt   = SFL_ANSWER;
        end else if (!prog_req_o) begin
          prog_req_nxt  = 1'b1;
          prog_data_nxt = pkt.pkt_data[4'(idx_r + 4'h1)];
        end else if (prog_done_i) begin
          prog_req_nxt = 1'b0;
          if (prog_err_i) begin
            // Nothing committed, so the host resends the same chunk
            tx_byte_nxt = `SFL_NAK;
            state_nxt   = SFL_ANSWER;
          end else begin
            prog_addr_nxt = prog_addr_o + 32'h1;
            rem_work_nxt  = rem_work_r - 32'h1;
            idx_nxt       = idx_r + 4'h1;
          end
        end
      end
      SFL_ANSWER: begin
        if (tx_ready_i) begin
          // Action only after the answer byte has left
          run_nxt      = (act_r == SFL_ACT_RUN);
          sw_reset_nxt = (act_r == SFL_ACT_RST);
          act_nxt      = SFL_ACT_NONE;
          state_nxt    = SFL_IDLE;
        end
      end
      default: state_nxt = SFL_IDLE;
    endcase
    tx_valid_nxt = (state_nxt == SFL_ANSWER);
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_r      <= SFL_IDLE;
      act_r        <= SFL_ACT_NONE;
      wr_addr_r    <= 32'h0;
      remain_r     <= 32'h0;
      rem_work_r   <= 32'h0;
      chunk_ok_r   <= 1'b0;
      idx_r        <= 4'h0;
      nbytes_r     <= 4'h0;
      tx_valid_o   <= 1'b0;
      tx_byte_o    <= 8'h00;
      erase_req_o  <= 1'b0;
      erase_addr_o <= 32'h0;
      erase_len_o  <= 32'h0;
      prog_req_o   <= 1'b0;
      prog_addr_o  <= 32'h0;
      prog_data_o  <= 8'h00;
      run_o        <= 1'b0;
      run_addr_o   <= 32'h0;
      sw_reset_o   <= 1'b0;
    end else begin
      state_r      <= state_nxt;
      act_r        <= act_nxt;
      wr_addr_r    <= wr_addr_nxt;
      remain_r     <= remain_nxt;
      rem_work_r   <= rem_work_nxt;
      chunk_ok_r   <= chunk_ok_nxt;
      idx_r        <= idx_nxt;
      nbytes_r     <= nbytes_nxt;
      tx_valid_o   <= tx_valid_nxt;
      tx_byte_o    <= tx_byte_nxt;
      erase_req_o  <= erase_req_nxt;
      erase_addr_o <= erase_addr_nxt;
      erase_len_o  <= erase_len_nxt;
      prog_req_o   <= prog_req_nxt;
      prog_addr_o  <= prog_addr_nxt;
      prog_data_o  <= prog_data_nxt;
      run_o        <= run_nxt;
      run_addr_o   <= run_addr_nxt;
      sw_reset_o   <= sw_reset_nxt;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  sequence s_ack_leaves;
    tx_valid_o && tx_ready_i && tx_byte_o == `SFL_ACK;
  endsequence

  AST_ACK_BEFORE_RUN: assert property (run_o |-> $past(tx_valid_o && tx_ready_i && tx_byte_o == `SFL_ACK))
    else $error("Jump started without a prior acknowledge");
  AST_ACK_THEN_RESET: assert property ((s_ack_leaves and act_r == SFL_ACT_RST) |=> sw_reset_o)
    else $error("Restart acknowledge not followed by reset");
  AST_NO_ANSWER_IN_ERASE: assert property (erase_req_o |-> !tx_valid_o)
    else $error("Answer sent while erase in progress");
  AST_BAD_SUM_REJECT: assert property ((state_r == SFL_IDLE && pkt.pkt_valid && !pkt.pkt_good)
    |=> tx_valid_o && tx_byte_o == `SFL_NAK)
    else $error("Bad packet not rejected");
  AST_SETUP_LEN_REJECT: assert property ((state_r == SFL_IDLE && pkt.pkt_valid && pkt.pkt_good
    && cmd == `SFL_CMD_SETUP && pkt.pkt_len != `SFL_LEN_SETUP) |=> tx_byte_o == `SFL_NAK && !erase_req_o)
    else $error("Setup with wrong length accepted");
  AST_PROG_WITHIN_COUNT: assert property (prog_req_o |-> rem_work_r != 32'h0)
    else $error("Programming beyond the byte count");
  AST_ADDR_ONLY_ON_ACCEPT: assert property ((wr_addr_r != $past(wr_addr_r))
    |-> state_r == SFL_ERASE || (tx_valid_o && tx_byte_o == `SFL_ACK))
    else $error("Running address moved without acceptance");
  AST_ADDR_STEP: assert property ((state_r == SFL_PROG && prog_req_o && prog_done_i && !prog_err_i)
    |=> prog_addr_o == $past(prog_addr_o) + 32'h1)
    else $error("Program address did not advance by one");
  AST_JUMP_ACK: assert property ((state_r == SFL_IDLE && pkt.pkt_valid && pkt.pkt_good
    && cmd == `SFL_CMD_JUMP && pkt.pkt_len == `SFL_LEN_JUMP) |=> tx_valid_o && tx_byte_o == `SFL_ACK ##1 run_addr_o == $past(word_a, 2))
    else $error("Valid jump not acknowledged with its address");
endmodule

// ---- rtl/sfl_params.svh ----
`ifndef SFL_PARAMS_SVH
`define SFL_PARAMS_SVH

// Command codes
`define SFL_CMD_SETUP     8'h21
`define SFL_CMD_JUMP      8'h22
`define SFL_CMD_CHUNK     8'h24
`define SFL_CMD_RESTART   8'h25

// Answer bytes
`define SFL_ACK           8'hCC
`define SFL_NAK           8'h33

// Packet lengths, size and sum bytes included
`define SFL_LEN_SETUP     8'h0B
`define SFL_LEN_JUMP      8'h07
`define SFL_LEN_RESTART   8'h03
`define SFL_LEN_CHUNK_MIN 8'h04
`define SFL_LEN_MAX       8'h0B
`define SFL_LEN_HDR       8'h02
`define SFL_LEN_MIN       8'h03

// Stored data bytes: command plus eight
`define SFL_BUF_BYTES     9
`define SFL_BUF_LAST      4'h8

`endif

// ---- rtl/sfl_pkg.sv ----
package sfl_pkg;
  typedef enum logic [1:0] {
    SFL_HUNT,
    SFL_SUM,
    SFL_DATA
  } sfl_asm_state_type;

  typedef enum logic [2:0] {
    SFL_IDLE,
    SFL_ERASE,
    SFL_PROG,
    SFL_ANSWER
  } sfl_cmd_state_type;

  typedef enum logic [1:0] {
    SFL_ACT_NONE,
    SFL_ACT_RUN,
    SFL_ACT_RST
  } sfl_act_type;
endpackage

// ---- rtl/sfl_pkt_if.sv ----
`timescale 1ns/10ps
interface sfl_pkt_if;
  logic       pkt_valid;
  logic       pkt_good;
  logic [7:0] pkt_len;
  logic [7:0] pkt_data [0:8];
  logic       busy;

  modport asm_mp (output pkt_valid, output pkt_good, output pkt_len, output pkt_data, input busy);
  modport cmd_mp (input pkt_valid, input pkt_good, input pkt_len, input pkt_data, output busy);
endinterface

// ---- verif/serial_loader_flash_commands_tb.sv ----
`timescale 1ns/10ps
module serial_loader_flash_commands_tb;
  logic        clk_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic        rx_valid_i = 1'b0;
  logic [7:0]  rx_byte_i = 8'h00;
  logic        tx_ready_i = 1'b0;
  logic [7:0]  lat = 8'h02;
  logic        fail = 1'b0;
  logic        tx_valid_o, erase_req_o, erase_done_i, erase_err_i, prog_req_o;
  logic        prog_done_i, prog_err_i, run_o, sw_reset_o;
  logic [7:0]  tx_byte_o, prog_data_o;
  logic [31:0] erase_addr_o, erase_len_o, prog_addr_o, run_addr_o;
  int          mismatches = 0;
  int          cmp_count = 0;
  int          seed = 77;
  int          acts = 0;
  int          overlap = 0;
  logic [31:0] ea, el, wa, a;
  logic [31:0] pa_q[$];
  logic [7:0]  pd_q[$];
  logic [7:0]  ck[$];

  always #5 clk_i = ~clk_i;

  sfl_cmd u_dut (
    .clk_i(clk_i), .resetn_i(resetn_i), .rx_valid_i(rx_valid_i), .rx_byte_i(rx_byte_i),
    .tx_valid_o(tx_valid_o), .tx_byte_o(tx_byte_o), .tx_ready_i(tx_ready_i),
    .erase_req_o(erase_req_o), .erase_addr_o(erase_addr_o), .erase_len_o(erase_len_o),
    .erase_done_i(erase_done_i), .erase_err_i(erase_err_i), .prog_req_o(prog_req_o),
    .prog_addr_o(prog_addr_o), .prog_data_o(prog_data_o), .prog_done_i(prog_done_i),
    .prog_err_i(prog_err_i), .run_o(run_o), .run_addr_o(run_addr_o), .sw_reset_o(sw_reset_o));

  sfl_flash_model u_flash (
    .clk_i(clk_i), .resetn_i(resetn_i), .erase_req_i(erase_req_o), .prog_req_i(prog_req_o),
    .lat_i(lat), .fail_i(fail), .erase_done_o(erase_done_i), .erase_err_o(erase_err_i),
    .prog_done_o(prog_done_i), .prog_err_o(prog_err_i));

  // Records every byte the flash takes and any answer raised during an erase
  always @(posedge clk_i) begin
    if (prog_req_o && prog_done_i) begin
      pa_q.push_back(prog_addr_o);
      pd_q.push_back(prog_data_o);
    end
    if (run_o || sw_reset_o)
      acts++;
    if (erase_req_o) begin
      ea = erase_addr_o;
      el = erase_len_o;
      if (tx_valid_o)
        overlap++;
    end
  end

  function automatic logic [7:0] f_sum(input logic [7:0] d[$]);
    logic [7:0] s;
    s = 8'h00;
    foreach (d[i])
      s += d[i];
    return s;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t seen %h expected %h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("Comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Sends one packet, then takes the answer after a random stall
  task automatic cmd(input string nm, input logic [7:0] d[$], input logic [7:0] bad, input logic [7:0] exp);
    logic [7:0] p[$];
    int         n;
    int         a0;
    a0 = acts;
    p = {8'h00, 8'h00, 8'(d.size() + 2), f_sum(d) ^ bad};
    p = {p, d};
    foreach (p[i]) begin
      @(posedge clk_i);
      #1;
      rx_valid_i = 1'b1;
      rx_byte_i = p[i];
    end
    @(posedge clk_i);
    #1;
    rx_valid_i = 1'b0;
    rx_byte_i = 8'($random(seed));
    n = 0;
    while (tx_valid_o !== 1'b1 && n < 1000) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    repeat ($random(seed) & 3) @(posedge clk_i);
    #1;
    chk(tx_valid_o, 1'b1);
    chk(tx_byte_o, exp);
    chk(acts, a0);
    tx_ready_i = 1'b1;
    @(posedge clk_i);
    #1;
    tx_ready_i = 1'b0;
    $display("test %s done", nm);
  endtask

  initial begin
    #200000;
    mismatches++;
    complete_run();
  end

  initial begin
    repeat (16) @(posedge clk_i);
    #1;
    resetn_i = 1'b1;
    cmd("early chunk", {8'h24, 8'h5A}, 8'h00, 8'h33);
    cmd("bad sum", {8'h25}, 8'h01, 8'h33);
    cmd("short jump", {8'h22, 8'h01, 8'h02, 8'h03}, 8'h00, 8'h33);
    a = $random(seed);
    cmd("jump", {8'h22, a[31:24], a[23:16], a[15:8], a[7:0]}, 8'h00, 8'hCC);
    // Run pulse stands only in the cycle after the answer is taken
    chk(run_o, 1'b1);
    chk(run_addr_o, a);
    @(posedge clk_i);
    #1;
    chk(run_o, 1'b0);
    // Slow erase, so a premature answer would show as overlap
    lat = 8'h28;
    wa = $random(seed) & 32'hFFFF_FFF0;
    cmd("setup", {8'h21, wa[31:24], wa[23:16], wa[15:8], wa[7:0], 8'h00, 8'h00, 8'h00, 8'h14},
        8'h00, 8'hCC);
    chk(ea, wa);
    chk(el, 32'h0000_0014);
    chk(overlap, 0);
    // Chunks of eight follow the setup only; the third resends the refused second
    for (int k = 0; k < 4; k++) begin
      if (k != 2) begin
        ck = {8'h24};
        repeat (8) ck.push_back(8'($random(seed)));
      end
      fail = (k == 1);
      lat = 8'($random(seed)) & 8'h03;
      pa_q = {};
      pd_q = {};
      cmd("chunk", ck, 8'h00, fail ? 8'h33 : 8'hCC);
      if (!fail) begin
        chk(pa_q.size(), (k == 3) ? 4 : 8);
        foreach (pa_q[i]) begin
          chk(pa_q[i], wa + i);
          chk(pd_q[i], ck[i + 1]);
        end
        wa += 8;
      end
    end
    fail = 1'b0;
    // Result query is not served here, and it ends the chunk chain
    cmd("query after chunk", {8'h23}, 8'h00, 8'h33);
    cmd("chunk after query", ck, 8'h00, 8'h33);
    cmd("setup again", {8'h21, wa[31:24], wa[23:16], wa[15:8], wa[7:0], 8'h00, 8'h00, 8'h00, 8'h08},
        8'h00, 8'hCC);
    chk(el, 32'h0000_0008);
    cmd("query after setup", {8'h23}, 8'h00, 8'h33);
    cmd("restart", {8'h25}, 8'h00, 8'hCC);
    chk(sw_reset_o, 1'b1);
    @(posedge clk_i);
    #1;
    chk(sw_reset_o, 1'b0);
    complete_run();
  end
endmodule

// ---- verif/sfl_flash_model.sv ----
`timescale 1ns/10ps
module sfl_flash_model (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  // Requests from the interpreter
  input  wire logic       erase_req_i,
  input  wire logic       prog_req_i,
  // Bench controls
  input  wire logic [7:0] lat_i,
  input  wire logic       fail_i,
  // Answers
  output logic            erase_done_o,
  output logic            erase_err_o,
  output logic            prog_done_o,
  output logic            prog_err_o
);
  logic [7:0] cnt_r;
  logic       done_r;

  // Done blocks the count for a cycle so a request still held is not answered twice
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_r  <= 8'h00;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if ((erase_req_i || prog_req_i) && !done_r) begin
        if (cnt_r >= lat_i) begin
          cnt_r  <= 8'h00;
          done_r <= 1'b1;
        end else begin
          cnt_r <= cnt_r + 8'h01;
        end
      end
    end
  end

  assign erase_done_o = done_r && erase_req_i;
  assign prog_done_o  = done_r && prog_req_i;
  assign erase_err_o  = done_r && fail_i;
  assign prog_err_o   = done_r && fail_i;
endmodule
